// [rtl/fbpe_params.svh]
// Register offsets, field positions, reset values and the digital selection code for the four-bit port.
`ifndef FBPE_PARAMS_SVH
`define FBPE_PARAMS_SVH
`define FBPE_OFF_PINS 12'h000
`define FBPE_OFF_LATCH 12'h004
`define FBPE_OFF_DIR 12'h008
`define FBPE_OFF_CTRL 12'h00c
`define FBPE_OFF_PSPDATA 12'h010
`define FBPE_BIT_IBF 7
`define FBPE_BIT_OBF 6
`define FBPE_BIT_INPUT_OVERFLOW 5
`define FBPE_BIT_MODE 4
`define FBPE_DIR_RESET 3'h7
`define FBPE_ANALOG_RESET 3'h7
`define FBPE_DIGITAL_CFG 4'ha
`endif

// [rtl/fbpe_pkg.sv]
// Types shared by the four-bit port design.
package fbpe_pkg;
	typedef enum logic [1:0] {
		FBPE_IDLE = 2'b00,
		FBPE_WRITE = 2'b01,
		FBPE_READ = 2'b11
	} fbpe_strobe_type;
endpackage

// [rtl/fbpe_sync.sv]
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ns
module fbpe_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Data.
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);
	logic [W-1:0] meta_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= '0;
			syncOut <= '0;
		end else begin
			meta_r <= asyncIn;
			syncOut <= meta_r;
		end
	end
endmodule

// [rtl/fbpe_port.sv]
// Four-bit general-purpose port with slave-port status, behind an APB slave.
// How it works
// - Large package: four pins, three each selectable as input or output.
// - Direction bit one makes the pin an input with its driver off.
// - Direction bit zero drives the pin from its output latch bit.
// - Pins set analog read back as zero on the digital path.
// - Direction bits still control the drivers while pins are analog.
// - After reset the three configurable pins are analog inputs.
// - Latch register reads latched value; writes update it.
// - Fuse zero: fourth pin is digital input only, no direction or latch.
// - Fuse set: fourth pin is the external master clear input.
// - Small package: port exists only with fuse zero, fourth pin only.
// - Pin read bit 3 exists only with master clear disabled.
// - Input-buffer-full reads one while a received word is unread.
// - Output-buffer-full reads one until the host reads the word.
// - Host write onto an unread word sets overflow until software clears.
// - Mode bit one selects slave port, zero general-purpose port.
// - Direction register bit 3 reads zero.
// - Unimplemented upper bits of pin and latch registers read zero.
// - Slave mode: pin0 read strobe, pin1 write strobe, pin2 chip select.
// - End of a host write sets input-buffer-full and the event flag.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "fbpe_params.svh"
module fbpe_port
	import fbpe_pkg::*;
#(
	parameter bit LARGE_PKG = 1'b1
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Configuration fuse.
	input wire logic masterClearFuse,
	// Port pins.
	input wire logic [2:0] portPinIn,
	output logic [2:0] portPinOut,
	output logic [2:0] portPinOe,
	input wire logic portPin3Input,
	// Master clear request and slave-port data side.
	output logic masterClearReq,
	input wire logic [7:0] hostDataIn,
	output logic [7:0] hostDataOut,
	output logic slavePortEventFlag
);
	logic [2:0] pinSync;
	logic pin3Sync;
	logic [2:0] latch_r;
	logic [2:0] dir_r;
	logic [2:0] analog_r;
	logic [3:0] analogCfg_r;
	logic slavePortSelect_r;
	logic ibf_r;
	logic obf_r;
	logic input_overflow_r;
	logic [7:0] inWord_r;
	logic [7:0] outWord_r;
	logic event_r;
	fbpe_strobe_type strobe_r;
	fbpe_strobe_type strobe_nxt;
	logic [31:0] rdata_nxt;
	logic wrEn;
	logic rdEn;
	logic hostWriteEnd;
	logic hostReadStart;
	logic [3:0] pinRead;
	logic pin3Exists;

	fbpe_sync #(.W(4)) u_sync (
		.clk(clk),
		.rst(rst),
		.asyncIn({portPin3Input, portPinIn}),
		.syncOut({pin3Sync, pinSync})
	);

	// Single-cycle access phase; the slave never inserts wait states.
	assign wrEn = psel && penable && pwrite;
	assign rdEn = psel && penable && !pwrite;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction

	assign pin3Exists = !masterClearFuse;

	// Digital read path; analog pins read zero and absent pins read zero.
	always_comb begin
		pinRead = 4'h0;
		if (LARGE_PKG) begin
			pinRead[2:0] = pinSync & ~analog_r;
		end
		pinRead[3] = pin3Exists & pin3Sync;
	end

	// Analog selection resets to all-analog; the field makes pins digital.
	always_ff @(posedge clk) begin
		if (rst) begin
			analogCfg_r <= 4'h0;
			analog_r <= `FBPE_ANALOG_RESET;
		end else begin
			if (wrEn && hit(paddr, `FBPE_OFF_CTRL)) begin
				analogCfg_r <= pwdata[3:0];
			end
			analog_r <= (analogCfg_r == `FBPE_DIGITAL_CFG) ? 3'h0 : `FBPE_ANALOG_RESET;
		end
	end

	// Latch and direction. Only the large package implements them.
	always_ff @(posedge clk) begin
		if (rst) begin
			latch_r <= 3'h0;
			dir_r <= `FBPE_DIR_RESET;
			slavePortSelect_r <= 1'b0;
		end else if (LARGE_PKG && wrEn) begin
			if (hit(paddr, `FBPE_OFF_LATCH) || hit(paddr, `FBPE_OFF_PINS)) begin
				latch_r <= pwdata[2:0];
			end else if (hit(paddr, `FBPE_OFF_DIR)) begin
				dir_r <= pwdata[2:0];
				slavePortSelect_r <= pwdata[`FBPE_BIT_MODE];
			end
		end
	end

	// Drivers follow direction even in analog mode; software must keep inputs.
	always_ff @(posedge clk) begin
		if (rst) begin
			portPinOe <= 3'h0;
			portPinOut <= 3'h0;
		end else begin
			portPinOe <= LARGE_PKG ? ~dir_r : 3'h0;
			portPinOut <= latch_r;
		end
	end

	// Fuse set turns the fourth pin into master clear, active low.
	always_ff @(posedge clk) begin
		if (rst) begin
			masterClearReq <= 1'b0;
		end else begin
			masterClearReq <= masterClearFuse && !pin3Sync;
		end
	end

	// Strobes are active low; chip select gates both.
	always_comb begin
		strobe_nxt = FBPE_IDLE;
		if (LARGE_PKG && slavePortSelect_r && !pinSync[2]) begin
			if (!pinSync[1]) begin
				strobe_nxt = FBPE_WRITE;
			end else if (!pinSync[0]) begin
				strobe_nxt = FBPE_READ;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			strobe_r <= FBPE_IDLE;
		end else begin
			strobe_r <= strobe_nxt;
		end
	end

	assign hostWriteEnd = (strobe_r == FBPE_WRITE) && (strobe_nxt != FBPE_WRITE);
	assign hostReadStart = (strobe_r != FBPE_READ) && (strobe_nxt == FBPE_READ);

	// Host data capture and buffer flags; hardware set wins over software clear.
	always_ff @(posedge clk) begin
		if (rst) begin
			inWord_r <= 8'h00;
			ibf_r <= 1'b0;
			input_overflow_r <= 1'b0;
		end else begin
			if (hostWriteEnd) begin
				inWord_r <= hostDataIn;
				ibf_r <= 1'b1;
				if (ibf_r) begin
					input_overflow_r <= 1'b1;
				end
			end else if (rdEn && hit(paddr, `FBPE_OFF_PSPDATA)) begin
				ibf_r <= 1'b0;
			end
			if (!(hostWriteEnd && ibf_r) && wrEn && hit(paddr, `FBPE_OFF_DIR)
				&& !pwdata[`FBPE_BIT_INPUT_OVERFLOW]) begin
				input_overflow_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			outWord_r <= 8'h00;
			obf_r <= 1'b0;
		end else begin
			if (wrEn && hit(paddr, `FBPE_OFF_PSPDATA)) begin
				outWord_r <= pwdata[7:0];
				obf_r <= 1'b1;
			end else if (hostReadStart) begin
				obf_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hostDataOut <= 8'h00;
			event_r <= 1'b0;
			slavePortEventFlag <= 1'b0;
		end else begin
			hostDataOut <= outWord_r;
			if (hostWriteEnd || (strobe_r == FBPE_READ && strobe_nxt != FBPE_READ)) begin
				event_r <= 1'b1;
			end else if (wrEn && hit(paddr, `FBPE_OFF_CTRL) && pwdata[8]) begin
				event_r <= 1'b0;
			end
			slavePortEventFlag <= event_r;
		end
	end

	// Read mux; unimplemented bits stay zero.
	always_comb begin
		rdata_nxt = 32'h0;
		if (hit(paddr, `FBPE_OFF_PINS)) begin
			rdata_nxt[3:0] = pinRead;
		end else if (hit(paddr, `FBPE_OFF_LATCH)) begin
			rdata_nxt[2:0] = LARGE_PKG ? latch_r : 3'h0;
		end else if (hit(paddr, `FBPE_OFF_DIR)) begin
			if (LARGE_PKG) begin
				rdata_nxt[2:0] = dir_r;
				rdata_nxt[`FBPE_BIT_MODE] = slavePortSelect_r;
				rdata_nxt[`FBPE_BIT_INPUT_OVERFLOW] = input_overflow_r;
				rdata_nxt[`FBPE_BIT_OBF] = obf_r;
				rdata_nxt[`FBPE_BIT_IBF] = ibf_r;
			end
			rdata_nxt[3] = 1'b0;
		end else if (hit(paddr, `FBPE_OFF_CTRL)) begin
			rdata_nxt[3:0] = analogCfg_r;
			rdata_nxt[8] = event_r;
		end else if (hit(paddr, `FBPE_OFF_PSPDATA)) begin
			rdata_nxt[7:0] = inWord_r;
		end
	end

	// Answer is registered from the setup phase, so pready is high in the access phase; read data is held in a flop.
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= rdata_nxt;
			pready <= psel && !penable;
			pslverr <= psel && !penable && !(hit(paddr, `FBPE_OFF_PINS)
				|| hit(paddr, `FBPE_OFF_LATCH) || hit(paddr, `FBPE_OFF_DIR)
				|| hit(paddr, `FBPE_OFF_CTRL) || hit(paddr, `FBPE_OFF_PSPDATA));
		end
	end

	// Assertions.
	drive_dir_a: assert property (@(posedge clk) disable iff (rst)
		portPinOe == (LARGE_PKG ? ~$past(dir_r) : 3'h0))
		else $error("pin enable does not follow direction");
	drive_val_a: assert property (@(posedge clk) disable iff (rst)
		portPinOut == $past(latch_r))
		else $error("pin output does not follow latch");
	analog_zero_a: assert property (@(posedge clk) disable iff (rst)
		(hit(paddr, `FBPE_OFF_PINS) && analog_r == 3'h7) |-> rdata_nxt[2:0] == 3'h0)
		else $error("analog pin read nonzero");
	pin3_fuse_a: assert property (@(posedge clk) disable iff (rst)
		masterClearFuse |-> pinRead[3] == 1'b0)
		else $error("fourth pin read with master clear active");
	ibf_set_a: assert property (@(posedge clk) disable iff (rst)
		hostWriteEnd |=> ibf_r && event_r)
		else $error("host write end did not set flags");
	input_overflow_set_a: assert property (@(posedge clk) disable iff (rst)
		(hostWriteEnd && ibf_r) |=> input_overflow_r)
		else $error("overflow not flagged");
	obf_set_a: assert property (@(posedge clk) disable iff (rst)
		(wrEn && hit(paddr, `FBPE_OFF_PSPDATA)) |=> obf_r)
		else $error("output buffer full not set");
	dir_bit3_a: assert property (@(posedge clk) disable iff (rst)
		hit(paddr, `FBPE_OFF_DIR) |-> rdata_nxt[3] == 1'b0)
		else $error("direction bit 3 reads nonzero");
	obf_clr_a: assert property (@(posedge clk) disable iff (rst)
		(hostReadStart && !(wrEn && hit(paddr, `FBPE_OFF_PSPDATA))) |=> !obf_r)
		else $error("host read did not clear output buffer full");
endmodule

// [tb/fbpe_host.sv]
// Model of the external host and circuitry on the port pins.
`timescale 1ns/1ns
module fbpe_host (
	// Clock.
	input wire logic clk,
	// Pins and host data.
	input wire logic [2:0] portPinOut,
	input wire logic [2:0] portPinOe,
	output logic [2:0] portPinIn,
	output logic [7:0] hostDataIn
);
	logic [2:0] drv = 3'h7;
	logic [7:0] word = 8'h00;
	// A driven pin shows the port's level, so no two drivers ever fight.
	assign portPinIn = (portPinOe & portPinOut) | (~portPinOe & drv);
	assign hostDataIn = word;
	// Bit 0 read, bit 1 write, bit 2 select, all low active.
	task automatic strobe(input logic [2:0] lvl, input logic [7:0] d);
		begin
			@(posedge clk);
			drv <= lvl;
			word <= d;
			repeat (6) @(posedge clk);
			drv <= 3'h7;
			repeat (6) @(posedge clk);
			word <= ~d;
		end
	endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the four-bit port.
`timescale 1ns/1ns
`include "fbpe_params.svh"
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, v, d;
	logic pready, pslverr, err, mcReq, evFlag, sMc, sEv;
	logic fuse = 1'b0;
	logic pin3 = 1'b1;
	logic [2:0] pinIn, pinOut, pinOe, sOe, sOut;
	logic [7:0] hIn, hOut, sHo;
	logic [31:0] seed = 32'hcbdc;
	int errors = 0;
	int samplesChecked = 0;
	int cycles = 0;
	fbpe_port #(.LARGE_PKG(1'b1)) u_dut (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .masterClearFuse(fuse),
		.portPinIn(pinIn), .portPinOut(pinOut), .portPinOe(pinOe),
		.portPin3Input(pin3), .masterClearReq(mcReq), .hostDataIn(hIn),
		.hostDataOut(hOut), .slavePortEventFlag(evFlag));
	fbpe_host u_host (.clk(clk), .portPinOut(pinOut), .portPinOe(pinOe),
		.portPinIn(pinIn), .hostDataIn(hIn));
	always #5 clk = ~clk;
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] expDir(input logic [3:0] st, input logic [2:0] dr);
		return {24'h0, st, 1'b0, dr};
	endfunction
	function automatic logic [31:0] expPins(input logic f, input logic p3,
		input logic [2:0] p, input logic dig);
		return {28'h0, ~f & p3, dig ? p : 3'h0};
	endfunction
	task automatic close_out;
		if (errors == 0 && samplesChecked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Read data and error are taken at the edge where pready is seen high, then released.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge clk);
		end
		if (n >= 50) begin
			errors++;
			$display("[FAIL] %0t no bus answer", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic look;
		@(negedge clk);
		sOe = pinOe;
		sOut = pinOut;
		sMc = mcReq;
		sEv = evFlag;
		sHo = hOut;
		@(posedge clk);
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			close_out();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdchk(`FBPE_OFF_DIR, expDir(4'h0, 3'h7));
		look();
		chk({29'h0, sOe}, 32'h0);
		rdchk(`FBPE_OFF_PINS, expPins(1'b0, 1'b1, 3'h7, 1'b0));
		for (int i = 0; i < 8; i++) begin
			v = xs();
			apb(1'b1, i[0] ? `FBPE_OFF_PINS : `FBPE_OFF_LATCH, v);
			rdchk(`FBPE_OFF_LATCH, {29'h0, v[2:0]});
			apb(1'b1, `FBPE_OFF_DIR, {29'h0, v[5:3]});
			look();
			chk({29'h0, sOe}, {29'h0, ~v[5:3]});
			chk({29'h0, sOut & sOe}, {29'h0, v[2:0] & ~v[5:3]});
		end
		apb(1'b1, `FBPE_OFF_DIR, 32'h7);
		apb(1'b1, `FBPE_OFF_CTRL, 32'h0a);
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? 32'h07 : (i == 1) ? 32'h08 : xs();
			fuse <= v[3];
			pin3 <= v[4];
			u_host.drv <= v[2:0];
			repeat (4) @(posedge clk);
			rdchk(`FBPE_OFF_PINS, expPins(v[3], v[4], v[2:0], 1'b1));
			look();
			chk({31'h0, sMc}, {31'h0, v[3] & ~v[4]});
		end
		fuse <= 1'b0;
		pin3 <= 1'b1;
		u_host.drv <= 3'h7;
		apb(1'b1, `FBPE_OFF_DIR, 32'h17);
		d = xs();
		u_host.strobe(3'b001, d[7:0]);
		rdchk(`FBPE_OFF_DIR, expDir(4'h9, 3'h7));
		look();
		chk({31'h0, sEv}, 32'h1);
		u_host.strobe(3'b001, d[15:8]);
		rdchk(`FBPE_OFF_DIR, expDir(4'hb, 3'h7));
		rdchk(`FBPE_OFF_PSPDATA, {24'h0, d[15:8]});
		rdchk(`FBPE_OFF_DIR, expDir(4'h3, 3'h7));
		apb(1'b1, `FBPE_OFF_DIR, 32'h17);
		rdchk(`FBPE_OFF_DIR, expDir(4'h1, 3'h7));
		apb(1'b1, `FBPE_OFF_CTRL, 32'h10a);
		apb(1'b1, `FBPE_OFF_PSPDATA, {24'h0, d[23:16]});
		rdchk(`FBPE_OFF_DIR, expDir(4'h5, 3'h7));
		look();
		chk({24'h0, sHo}, {24'h0, d[23:16]});
		u_host.strobe(3'b010, 8'h00);
		rdchk(`FBPE_OFF_DIR, expDir(4'h1, 3'h7));
		apb(1'b0, 12'h014, 32'h0);
		chk({31'h0, err}, 32'h1);
		close_out();
	end
endmodule
